/* hw/dpa_pkg.sv */
// Purpose: Shared constants for the drive-profile assembly map
// Assumes: One 10 MHz clock, synchronous active-low reset
// Notes: Bus offsets are byte addresses on a 32-bit classic Wishbone
package dpa_pkg;
  // Assembly instance numbers
  localparam logic [7:0] INST_OUT_BASIC = 8'h14;
  localparam logic [7:0] INST_OUT_EXT = 8'h15;
  // Inverter register numbers
  localparam logic [15:0] REG_FREQ_CMD = 16'h0706;
  localparam logic [15:0] REG_OP_CMD = 16'h0707;
  // Consumed byte 0 bit positions
  localparam int ASM_FWD = 0;
  localparam int ASM_REV = 1;
  localparam int ASM_FCLR = 2;
  localparam int ASM_NET_CONTROL = 5;
  localparam int ASM_NET_REFERENCE = 6;
  // Operation command word bits
  localparam int OPW_FWD = 0;
  localparam int OPW_REV = 1;
  localparam int OPW_RST = 15;
  // Operation status word bits
  localparam int STS_FWD = 0;
  localparam int STS_REV = 1;
  localparam int STS_RISE = 9;
  localparam int STS_FALL = 10;
  localparam int STS_ALARM = 11;
  // Produced byte 0 bit positions
  localparam int PRD_FAULTED = 0;
  localparam int PRD_WARN = 1;
  localparam int PRD_RUN_FWD = 2;
  localparam int PRD_RUN_REV = 3;
  localparam int PRD_READY = 4;
  localparam int PRD_CTRL_NET = 5;
  localparam int PRD_REF_NET = 6;
  localparam int PRD_AT_REF = 7;
  // Speed conversion constant and divider length
  localparam logic [15:0] SPEED_K = 16'h0078;
  localparam logic [5:0] DIV_STEPS = 6'h20;
  localparam logic [15:0] SAT16 = 16'hFFFF;
  // Wishbone register offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_IRQ_STS = 8'h04;
  localparam logic [7:0] ADR_IRQ_MSK = 8'h08;
  localparam logic [7:0] ADR_MON = 8'h0C;
  // Reset values and event count
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int NUM_EV = 4;
  localparam logic [3:0] IRQ_MSK_RST = 4'h0;
  // Event bit positions
  localparam int EV_APPLY = 0;
  localparam int EV_RESET = 1;
  localparam int EV_ALARM = 2;
  localparam int EV_SAT = 3;
  // Control supervisor states, in profile order
  typedef enum logic [2:0] {
    ST_NON_EXIST, ST_STARTUP, ST_NOT_READY, ST_READY,
    ST_ENABLED, ST_STOPPING, ST_FAULT_STOP, ST_FAULTED
  } dpa_state_t;
endpackage : dpa_pkg

/* hw/dpa_divider.sv */
// Purpose: Restoring unsigned divider, 32 by 16 bits
// Assumes: start is ignored while busy
// Notes: Quotient comes straight from a register
`timescale 1ns/1ps
`default_nettype none
module dpa_divider (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic [31:0] dividend_in,
  input wire logic [15:0] divisor_in,
  output logic busy_out,
  output logic done_out,
  output logic [31:0] quotient_out
);
  logic [16:0] rem_q;
  logic [5:0] cnt_q;
  logic [15:0] div_q;
  wire [16:0] shifted = {rem_q[15:0], quotient_out[31]};
  wire fits = shifted >= {1'b0, div_q};
  wire [16:0] diff = shifted - {1'b0, div_q};

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      cnt_q <= 6'h00;
      rem_q <= 17'h0_0000;
      div_q <= 16'h0000;
      quotient_out <= 32'h0000_0000;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        busy_out <= 1'b1;
        cnt_q <= dpa_pkg::DIV_STEPS;
        rem_q <= 17'h0_0000;
        div_q <= divisor_in;
        quotient_out <= dividend_in;
      end else if (busy_out) begin
        rem_q <= fits ? diff : shifted;
        quotient_out <= {quotient_out[30:0], fits};
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule : dpa_divider
`default_nettype wire

/* hw/dpa_assembly_map.sv */
// Purpose: Maps drive-profile assemblies onto inverter command/status words
// Assumes: Consumed assembly arrives as a one-cycle strobe with 4 bytes
// Notes: Classic Wishbone slave for control, interrupts and monitor
`timescale 1ns/1ps
`default_nettype none
module dpa_assembly_map (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic con_valid_in,
  input wire logic [7:0] con_inst_in,
  input wire logic [31:0] con_data_in,
  input wire logic [15:0] operation_status_word_in,
  input wire logic [15:0] output_frequency_word_in,
  input wire logic [7:0] motor_pole_count_in,
  output logic inv_wr_stb_out,
  output logic [15:0] inv_wr_addr_out,
  output logic [15:0] inv_wr_data_out,
  output logic [31:0] prod70_out,
  output logic [31:0] prod71_out,
  output logic irq_out
);
  logic ctrl_en_q;
  logic [3:0] irq_sts_q;
  logic [3:0] irq_msk_q;
  logic boot_done_q;
  logic [7:0] pole_q;
  logic fclr_prev_q;
  logic apply_q;
  logic [15:0] op_word_q;
  logic [15:0] op_word_d;
  logic run_cmd_q;
  logic [15:0] rpm_q;
  logic conv_req_q;
  logic [15:0] freq_word_q;
  logic freq_pend_q;
  logic [15:0] speed_q;
  logic alarm_prev_q;
  dpa_pkg::dpa_state_t state_q;
  dpa_pkg::dpa_state_t state_d;
  logic a_busy;
  logic a_done;
  logic [31:0] a_quo;
  logic b_busy;
  logic b_done;
  logic [31:0] b_quo;

  wire is_basic = con_inst_in == dpa_pkg::INST_OUT_BASIC;
  wire is_ext = con_inst_in == dpa_pkg::INST_OUT_EXT;
  wire con_take = con_valid_in && ctrl_en_q && (is_basic || is_ext);
  wire fwd_cmd = con_data_in[dpa_pkg::ASM_FWD];
  // reverse only exists in the extended assembly
  wire rev_cmd = is_ext && con_data_in[dpa_pkg::ASM_REV];
  // reset only on a rising fault clear
  wire fclr_rise = con_take && con_data_in[dpa_pkg::ASM_FCLR] && !fclr_prev_q;
  wire [15:0] rpm_ref = con_data_in[31:16];

  // forward and reverse into command word
  always_comb begin
    op_word_d = 16'h0000;
    op_word_d[dpa_pkg::OPW_FWD] = fwd_cmd;
    op_word_d[dpa_pkg::OPW_REV] = rev_cmd;
    op_word_d[dpa_pkg::OPW_RST] = fclr_rise;
  end

  // pole count caught once after reset release
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      boot_done_q <= 1'b0;
      pole_q <= 8'h00;
    end else if (!boot_done_q) begin
      boot_done_q <= 1'b1;
      pole_q <= motor_pole_count_in;
    end
  end
  wire pole_ok = pole_q != 8'h00;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      fclr_prev_q <= 1'b0;
      apply_q <= 1'b0;
      op_word_q <= 16'h0000;
      run_cmd_q <= 1'b0;
      rpm_q <= 16'h0000;
    end else begin
      apply_q <= con_take;
      if (con_take) begin
        fclr_prev_q <= con_data_in[dpa_pkg::ASM_FCLR];
        op_word_q <= op_word_d;
        run_cmd_q <= fwd_cmd || rev_cmd;
        rpm_q <= rpm_ref;
      end
    end
  end

  wire [23:0] rpm_x_pole = 24'(rpm_q * pole_q);
  wire a_start = conv_req_q && boot_done_q && !a_busy;
  dpa_divider u_rpm_to_hz (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .start_in(a_start),
    .dividend_in({8'h00, rpm_x_pole}),
    .divisor_in(dpa_pkg::SPEED_K),
    .busy_out(a_busy),
    .done_out(a_done),
    .quotient_out(a_quo)
  );
  wire [22:0] hz_x_k = 23'(output_frequency_word_in * dpa_pkg::SPEED_K[6:0]);
  dpa_divider u_hz_to_rpm (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .start_in(boot_done_q && pole_ok),
    .dividend_in({9'h000, hz_x_k}),
    .divisor_in({8'h00, pole_q}),
    .busy_out(b_busy),
    .done_out(b_done),
    .quotient_out(b_quo)
  );
  // quotient is truncated; clamp the overflow
  wire a_sat = |a_quo[31:16];
  wire b_sat = |b_quo[31:16];
  wire [15:0] a_res = a_sat ? dpa_pkg::SAT16 : a_quo[15:0];
  wire [15:0] b_res = b_sat ? dpa_pkg::SAT16 : b_quo[15:0];

  // Newer request wins; a fresh reference starts a new conversion once the divider is idle
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      conv_req_q <= 1'b0;
      freq_word_q <= 16'h0000;
      freq_pend_q <= 1'b0;
      speed_q <= 16'h0000;
    end else begin
      conv_req_q <= con_take || (conv_req_q && !a_start);
      if (a_done) begin
        freq_word_q <= a_res;
      end
      freq_pend_q <= a_done || (freq_pend_q && apply_q);
      if (!pole_ok) begin
        speed_q <= 16'h0000;
      end else if (b_done) begin
        speed_q <= b_res;
      end
    end
  end

  // Command write wins the port; frequency waits a cycle
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      inv_wr_stb_out <= 1'b0;
      inv_wr_addr_out <= 16'h0000;
      inv_wr_data_out <= 16'h0000;
    end else begin
      inv_wr_stb_out <= apply_q || freq_pend_q;
      if (apply_q) begin
        inv_wr_addr_out <= dpa_pkg::REG_OP_CMD;
        inv_wr_data_out <= op_word_q;
      end else if (freq_pend_q) begin
        inv_wr_addr_out <= dpa_pkg::REG_FREQ_CMD;
        inv_wr_data_out <= freq_word_q;
      end
    end
  end

  // Status decode
  wire run_f = operation_status_word_in[dpa_pkg::STS_FWD];
  wire run_r = operation_status_word_in[dpa_pkg::STS_REV];
  wire alarm = operation_status_word_in[dpa_pkg::STS_ALARM];
  wire running = run_f || run_r;
  // up to speed when running and not ramping
  wire at_ref = running && !operation_status_word_in[dpa_pkg::STS_RISE]
      && !operation_status_word_in[dpa_pkg::STS_FALL];
  wire ready = (state_q == dpa_pkg::ST_READY) || (state_q == dpa_pkg::ST_ENABLED)
      || (state_q == dpa_pkg::ST_STOPPING);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dpa_pkg::ST_NON_EXIST: state_d = dpa_pkg::ST_STARTUP;
      dpa_pkg::ST_STARTUP: if (boot_done_q) state_d = dpa_pkg::ST_NOT_READY;
      dpa_pkg::ST_NOT_READY: if (!alarm) state_d = dpa_pkg::ST_READY;
      dpa_pkg::ST_READY: begin
        if (alarm) state_d = dpa_pkg::ST_FAULTED;
        else if (run_cmd_q) state_d = dpa_pkg::ST_ENABLED;
      end
      dpa_pkg::ST_ENABLED: begin
        if (alarm) state_d = dpa_pkg::ST_FAULT_STOP;
        else if (!run_cmd_q) state_d = dpa_pkg::ST_STOPPING;
      end
      dpa_pkg::ST_STOPPING: begin
        if (alarm) state_d = dpa_pkg::ST_FAULT_STOP;
        else if (run_cmd_q) state_d = dpa_pkg::ST_ENABLED;
        else if (!running) state_d = dpa_pkg::ST_READY;
      end
      dpa_pkg::ST_FAULT_STOP: if (!running) state_d = dpa_pkg::ST_FAULTED;
      dpa_pkg::ST_FAULTED: if (!alarm) state_d = dpa_pkg::ST_NOT_READY;
    endcase
  end

  // Produced byte 0 assembly
  logic [7:0] b0_70;
  logic [7:0] b0_71;
  always_comb begin
    b0_70 = 8'h00;
    b0_71 = 8'h00;
    b0_70[dpa_pkg::PRD_FAULTED] = alarm;
    b0_70[dpa_pkg::PRD_RUN_FWD] = run_f;
    b0_71[dpa_pkg::PRD_FAULTED] = alarm;
    b0_71[dpa_pkg::PRD_RUN_FWD] = run_f;
    b0_71[dpa_pkg::PRD_RUN_REV] = run_r;
    b0_71[dpa_pkg::PRD_READY] = ready;
    b0_71[dpa_pkg::PRD_AT_REF] = at_ref;
    b0_71[dpa_pkg::PRD_WARN] = 1'b0;
    b0_71[dpa_pkg::PRD_CTRL_NET] = 1'b0;
    b0_71[dpa_pkg::PRD_REF_NET] = 1'b0;
  end

  // speed low byte in byte 2
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state_q <= dpa_pkg::ST_STARTUP;
      prod70_out <= 32'h0000_0000;
      prod71_out <= 32'h0000_0000;
      alarm_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      prod70_out <= {speed_q, 8'h00, b0_70};
      prod71_out <= {speed_q, 5'h00, state_q, b0_71};
      alarm_prev_q <= alarm;
    end
  end

  // Wishbone slave, one wait state per access
  wire wb_req = wb_cyc_in && wb_stb_in;
  wire wb_fin = wb_req && wb_ack_out;
  wire wb_wr = wb_fin && wb_we_in && wb_sel_in[0];
  wire sel_ctrl = wb_adr_in == dpa_pkg::ADR_CTRL;
  wire sel_sts = wb_adr_in == dpa_pkg::ADR_IRQ_STS;
  wire sel_msk = wb_adr_in == dpa_pkg::ADR_IRQ_MSK;
  wire sel_mon = wb_adr_in == dpa_pkg::ADR_MON;
  wire [31:0] rd_mux = sel_ctrl ? {31'h0000_0000, ctrl_en_q}
      : sel_sts ? {28'h000_0000, irq_sts_q}
      : sel_msk ? {28'h000_0000, irq_msk_q}
      : sel_mon ? {20'h0_0000, boot_done_q, state_q, pole_q}
      : 32'h0000_0000;
  // Clearing only bits that were returned keeps later events
  wire [3:0] sts_clr = (wb_fin && !wb_we_in && sel_sts) ? wb_dat_out[3:0] : 4'h0;
  wire [3:0] events = {(a_done && a_sat) || (b_done && b_sat && pole_ok),
      alarm && !alarm_prev_q, apply_q && op_word_q[dpa_pkg::OPW_RST], apply_q};

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
      ctrl_en_q <= dpa_pkg::CTRL_EN_RST;
      irq_msk_q <= dpa_pkg::IRQ_MSK_RST;
      irq_sts_q <= 4'h0;
      irq_out <= 1'b0;
    end else begin
      wb_ack_out <= wb_req && !wb_ack_out;
      if (wb_req && !wb_ack_out) begin
        wb_dat_out <= rd_mux;
      end
      if (wb_wr && sel_ctrl) begin
        ctrl_en_q <= wb_dat_in[0];
      end
      if (wb_wr && sel_msk) begin
        irq_msk_q <= wb_dat_in[3:0];
      end
      // Set wins over a read clear
      irq_sts_q <= (irq_sts_q & ~sts_clr) | events;
      irq_out <= |(irq_sts_q & irq_msk_q);
    end
  end

  property p_fwd_copy;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    con_take |-> ##2 inv_wr_stb_out && inv_wr_addr_out == dpa_pkg::REG_OP_CMD
        && inv_wr_data_out[0] == $past(fwd_cmd, 2);
  endproperty
  a_fwd_copy: assert property (p_fwd_copy) else $error("forward bit not copied");

  property p_rev_copy;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    con_take |-> ##2 inv_wr_data_out[1] == $past(rev_cmd, 2);
  endproperty
  a_rev_copy: assert property (p_rev_copy) else $error("reverse bit not copied");

  property p_rst_edge;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    inv_wr_stb_out && inv_wr_addr_out == dpa_pkg::REG_OP_CMD && inv_wr_data_out[15]
        |-> $past(fclr_rise, 2);
  endproperty
  a_rst_edge: assert property (p_rst_edge) else $error("reset without rising edge");

  property p_net_ignored;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    inv_wr_stb_out && inv_wr_addr_out == dpa_pkg::REG_OP_CMD |-> inv_wr_data_out[14:2] == 13'h0000;
  endproperty
  a_net_ignored: assert property (p_net_ignored) else $error("stray command bits");

  property p_freq_write;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    a_start |-> ##[33:36] inv_wr_stb_out && inv_wr_addr_out == dpa_pkg::REG_FREQ_CMD;
  endproperty
  a_freq_write: assert property (p_freq_write) else $error("frequency write late");

  property p_pole_hold;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    boot_done_q |=> $stable(pole_q) && boot_done_q;
  endproperty
  a_pole_hold: assert property (p_pole_hold) else $error("pole count changed");

  property p_fault_copy;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    ##1 prod70_out[0] == $past(alarm) && prod71_out[0] == prod70_out[0];
  endproperty
  a_fault_copy: assert property (p_fault_copy) else $error("faulted flag wrong");

  property p_zero_flags;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    prod71_out[6:5] == 2'h0 && !prod71_out[1];
  endproperty
  a_zero_flags: assert property (p_zero_flags) else $error("unused flag set");

  property p_run_copy;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    ##1 prod71_out[2] == $past(run_f) && prod71_out[3] == $past(run_r);
  endproperty
  a_run_copy: assert property (p_run_copy) else $error("running flag wrong");

  property p_ready;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    ##1 prod71_out[4] == (prod71_out[10:8] inside {3'h3, 3'h4, 3'h5}) || $changed(state_q);
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag wrong");

  property p_at_ref;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    ##1 prod71_out[7] == ($past(running) && !$past(operation_status_word_in[9])
        && !$past(operation_status_word_in[10]));
  endproperty
  a_at_ref: assert property (p_at_ref) else $error("at-speed flag wrong");

  property p_zero_pole;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    boot_done_q && !pole_ok |-> ##2 prod70_out[31:16] == 16'h0000;
  endproperty
  a_zero_pole: assert property (p_zero_pole) else $error("speed with zero poles");

  property p_irq;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    ##1 irq_out == |($past(irq_sts_q) & $past(irq_msk_q));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule : dpa_assembly_map
`default_nettype wire

/* sim/dpa_net_model.sv */
// Purpose: Network controller model that hands over consumed assemblies
// Assumes: One assembly per call, strobed for one clock
// Notes: Lines are scrambled outside the strobe so stale data never helps
`timescale 1ns/1ps
`default_nettype none
module dpa_net_model (
  input wire logic sys_clk_in,
  output logic con_valid_out,
  output logic [7:0] con_inst_out,
  output logic [31:0] con_data_out
);
  initial begin
    con_valid_out = 1'b0;
    con_inst_out = 8'h00;
    con_data_out = 32'h0000_0000;
  end
  task automatic send(input logic [7:0] inst, input logic [7:0] flags, input logic [15:0] speed);
    @(posedge sys_clk_in);
    con_valid_out <= 1'b1;
    con_inst_out <= inst;
    con_data_out <= {speed, 8'h00, flags};
    @(posedge sys_clk_in);
    con_valid_out <= 1'b0;
    con_inst_out <= ~inst;
    con_data_out <= ~{speed, 8'h00, flags};
  endtask : send
endmodule : dpa_net_model
`default_nettype wire

/* sim/tb.sv */
// Purpose: Self-checking bench for the assembly map
// Assumes: Hand-over timing of the bus and inverter write strobe
// Notes: Inverter writes are queued so slow conversions are not missed
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [15:0] sts = 16'h0000;
  logic [15:0] freq = 16'h003C;
  logic [7:0] poles = 8'h04;
  logic [31:0] rdat, con_data, p70, p71;
  logic ack, con_valid, wr_stb, irq;
  logic [7:0] con_inst;
  logic [15:0] wr_addr, wr_data;
  logic [31:0] wq[$];
  logic [31:0] q;
  int num_errors = 0;
  int compares = 0;
  logic [7:0] fl[4] = '{8'h07, 8'h05, 8'h00, 8'h04};
  logic [15:0] ex[4] = '{16'h8001, 16'h0001, 16'h0000, 16'h8000};

  always #50 clk = ~clk;

  dpa_net_model i_net (.sys_clk_in(clk), .con_valid_out(con_valid), .con_inst_out(con_inst),
    .con_data_out(con_data));

  dpa_assembly_map i_dut (.sys_clk_in(clk), .rst_b_in(rst_b), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .con_valid_in(con_valid), .con_inst_in(con_inst), .con_data_in(con_data),
    .operation_status_word_in(sts), .output_frequency_word_in(freq), .motor_pole_count_in(poles),
    .inv_wr_stb_out(wr_stb), .inv_wr_addr_out(wr_addr), .inv_wr_data_out(wr_data),
    .prod70_out(p70), .prod71_out(p71), .irq_out(irq));

  always @(posedge clk) begin
    if (wr_stb === 1'b1) begin
      wq.push_back({wr_addr, wr_data});
    end
  end

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Holds the request until ack is sampled high at an edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
  endtask : wb

  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, r);
    chk(what, exp, r);
  endtask : rd_chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  // Frequency write trails by some 35 cycles, so the wait is generous
  task exp_wr(input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (wq.size() == 0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (wq.size() == 0) begin
      num_errors++;
      $display("CHECK FAILED inverter write expected %h seen none", {a, d});
      report_and_stop();
    end
    chk("inverter write", {a, d}, wq.pop_front());
  endtask : exp_wr

  task boot(input logic [7:0] p);
    poles <= p;
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // Speed divider needs a full pass before the first produced check
    repeat (40) @(posedge clk);
    wq.delete();
  endtask : boot

  task prod_chk(input logic [15:0] s, input logic [2:0] st, input logic [15:0] spd);
    logic [7:0] b0;
    sts <= s;
    repeat (4) @(posedge clk);
    b0 = {(s[0] | s[1]) & ~s[9] & ~s[10], 2'b00, st inside {3'h3, 3'h4, 3'h5}, s[1], s[0], 1'b0, s[11]};
    chk("assembly 70", {spd, 8'h00, 5'h00, s[0], 1'b0, s[11]}, p70);
    chk("assembly 71", {spd, 5'h00, st, b0}, p71);
  endtask : prod_chk

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    boot(8'h04);
    rd_chk("control", dpa_pkg::ADR_CTRL, 32'h0000_0001);
    rd_chk("mask", dpa_pkg::ADR_IRQ_MSK, 32'h0000_0000);
    rd_chk("monitor", dpa_pkg::ADR_MON, 32'h0000_0B04);
    rd_chk("unmapped", 8'h10, 32'h0000_0000);
    $display("test registers done");
    prod_chk(16'h0001, 3'h3, 16'h0708);
    prod_chk(16'h0201, 3'h3, 16'h0708);
    prod_chk(16'h0402, 3'h3, 16'h0708);
    prod_chk(16'h0003, 3'h3, 16'h0708);
    prod_chk(16'h0800, 3'h7, 16'h0708);
    prod_chk(16'h0000, 3'h3, 16'h0708);
    rd_chk("status", dpa_pkg::ADR_IRQ_STS, 32'h0000_0004);
    rd_chk("status", dpa_pkg::ADR_IRQ_STS, 32'h0000_0000);
    $display("test produced done");
    wr(dpa_pkg::ADR_IRQ_MSK, 32'h0000_0001);
    // 1799 rpm at four poles leaves a fraction
    i_net.send(8'h15, 8'h63, 16'h0707);
    exp_wr(dpa_pkg::REG_OP_CMD, 16'h0003);
    exp_wr(dpa_pkg::REG_FREQ_CMD, 16'h003B);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    prod_chk(16'h0001, 3'h4, 16'h0708);
    rd_chk("status", dpa_pkg::ADR_IRQ_STS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    for (int i = 0; i < 4; i++) begin
      i_net.send(dpa_pkg::INST_OUT_BASIC, fl[i], 16'h0000);
      exp_wr(dpa_pkg::REG_OP_CMD, ex[i]);
      exp_wr(dpa_pkg::REG_FREQ_CMD, 16'h0000);
    end
    rd_chk("status", dpa_pkg::ADR_IRQ_STS, 32'h0000_0003);
    i_net.send(dpa_pkg::INST_OUT_BASIC, 8'h01, 16'h0000);
    exp_wr(dpa_pkg::REG_OP_CMD, 16'h0001);
    exp_wr(dpa_pkg::REG_FREQ_CMD, 16'h0000);
    prod_chk(16'h0001, 3'h4, 16'h0708);
    i_net.send(dpa_pkg::INST_OUT_BASIC, 8'h00, 16'h0000);
    exp_wr(dpa_pkg::REG_OP_CMD, 16'h0000);
    exp_wr(dpa_pkg::REG_FREQ_CMD, 16'h0000);
    prod_chk(16'h0001, 3'h5, 16'h0708);
    prod_chk(16'h0801, 3'h6, 16'h0708);
    prod_chk(16'h0800, 3'h7, 16'h0708);
    prod_chk(16'h0000, 3'h3, 16'h0708);
    rd_chk("status", dpa_pkg::ADR_IRQ_STS, 32'h0000_0005);
    wr(dpa_pkg::ADR_CTRL, 32'h0000_0000);
    i_net.send(8'h15, 8'h01, 16'h0708);
    wr(dpa_pkg::ADR_CTRL, 32'h0000_0001);
    i_net.send(8'h16, 8'h01, 16'h0708);
    repeat (60) @(posedge clk);
    chk("ignored writes", 32'h0000_0000, 32'(wq.size()));
    $display("test consumed done");
    freq <= 16'hFFFF;
    // Two divider passes may be needed before the new input shows
    repeat (80) @(posedge clk);
    chk("saturated speed", 32'h0000_FFFF, {16'h0000, p70[31:16]});
    rd_chk("status", dpa_pkg::ADR_IRQ_STS, 32'h0000_0008);
    $display("test saturation done");
    freq <= 16'h003C;
    poles <= 8'h02;
    repeat (80) @(posedge clk);
    chk("speed after pole change", 32'h0000_0708, {16'h0000, p70[31:16]});
    wb(1'b0, dpa_pkg::ADR_MON, 32'h0000_0000, q);
    chk("pole count", 32'h0000_0004, {24'h00_0000, q[7:0]});
    boot(8'h00);
    repeat (60) @(posedge clk);
    chk("speed no poles", 32'h0000_0000, {16'h0000, p70[31:16]});
    i_net.send(8'h15, 8'h01, 16'h0708);
    exp_wr(dpa_pkg::REG_OP_CMD, 16'h0001);
    exp_wr(dpa_pkg::REG_FREQ_CMD, 16'h0000);
    $display("test reboot done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
